/* File: hw/amp_input_net.sv */
`timescale 1ns/100ps
`default_nettype none
module amp_input_net (
    amp_cfg_if.net cfg
);
    always_comb begin
        cfg.pos_src     = pin_ctrl_pkg::SRC_GND;
        cfg.neg_src     = pin_ctrl_pkg::SRC_GND;
        cfg.pos_res     = 1'b0;
        cfg.inner_gain  = 1'b0;
        cfg.trim_sel    = cfg.trim_bg;
        if (cfg.cal_mode) begin
            case (cfg.in_sel)
                pin_ctrl_pkg::SEL_POS_GAIN: begin
                    cfg.pos_src = pin_ctrl_pkg::SRC_TRIM;
                    cfg.neg_src = pin_ctrl_pkg::SRC_TRIM;
                end
                pin_ctrl_pkg::SEL_NEG_GAIN: begin
                    cfg.inner_gain = 1'b1;
                end
                pin_ctrl_pkg::SEL_NEG_RES: begin
                    cfg.pos_res    = 1'b1;
                    cfg.inner_gain = 1'b1;
                end
                default: begin
                    cfg.pos_src = pin_ctrl_pkg::SRC_PIN;
                    cfg.neg_src = pin_ctrl_pkg::SRC_PIN;
                end
            endcase
        end else begin
            case (cfg.in_sel)
                pin_ctrl_pkg::SEL_POS_GAIN: begin
                    cfg.pos_src    = pin_ctrl_pkg::SRC_PIN;
                    cfg.inner_gain = 1'b1;
                end
                pin_ctrl_pkg::SEL_NEG_GAIN: begin
                    cfg.neg_src    = pin_ctrl_pkg::SRC_PIN;
                    cfg.inner_gain = 1'b1;
                end
                pin_ctrl_pkg::SEL_NEG_RES: begin
                    cfg.neg_src    = pin_ctrl_pkg::SRC_PIN;
                    cfg.pos_res    = 1'b1;
                    cfg.inner_gain = 1'b1;
                end
                default: begin
                    cfg.pos_src = pin_ctrl_pkg::SRC_PIN;
                    cfg.neg_src = pin_ctrl_pkg::SRC_PIN;
                end
            endcase
        end
    end

    // pins are claimed only while the amplifier is powered
    assign cfg.pin_p10_amp = cfg.enable && (cfg.pos_src == pin_ctrl_pkg::SRC_PIN);
    assign cfg.pin_p11_amp = cfg.enable && (cfg.neg_src == pin_ctrl_pkg::SRC_PIN);
    assign cfg.pin_p16_out = cfg.enable && cfg.out_en;
endmodule // amp_input_net
`default_nettype wire

/* File: hw/analog_peripheral_pin_control.sv */
// Notes on behaviour
// - comparator one enable claims P1.3, P1.4
// - comparator two enable claims P1.5
// - comparator three enable claims P1.7
// - comparator four enable claims P1.6
// - comparator five enable claims P3.2
// - serial master enable claims P3.0, P3.1
// - amplifier enable powers amplifier, gates pin roles
// - P1.6 output needs output and amplifier enable
// - normal mode input select network table
// - calibration mode input select network table
// - mode bit picks normal or calibration
`timescale 1ns/100ps
`default_nettype none
module analog_peripheral_pin_control (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // special function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output var  logic [7:0] sfr_rdata_o,
    output var  logic       sfr_hit_o,
    // two-wire master status from the serial engine
    input  wire logic       serial_ack_in_i,
    // comparator control
    output var  logic [4:0] comparator_enable_o,
    output var  logic [4:0] comparator_pin_claim_o,
    output var  logic       comparator_one_pin_p14_o,
    // serial master
    output var  logic       serial_master_enable_o,
    output var  logic       serial_pins_claim_o,
    output var  logic [6:0] two_wire_master_ctrl_o,
    // amplifier
    output var  logic       amplifier_power_o,
    output var  logic       amplifier_pin_p10_o,
    output var  logic       amplifier_pin_p11_o,
    output var  logic       amplifier_pin_p16_out_o,
    output var  logic [1:0] amplifier_pos_src_o,
    output var  logic [1:0] amplifier_neg_src_o,
    output var  logic       amplifier_pos_res_o,
    output var  logic       amplifier_inner_gain_o,
    output var  logic       amplifier_trim_bg_o,
    output var  logic [4:0] amplifier_trim_adj_o,
    output var  logic [1:0] amplifier_gain_o,
    // comparator analogue settings
    output var  logic [6:0] comparator_setting_o [5]
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] cmp_reg [5];
    logic [7:0] mser_reg;
    logic [7:0] ampc_reg;
    logic [7:0] ampk_reg;
    logic       ack_meta_reg;
    logic       ack_sync_reg;
    amp_cfg_if  amp ();

    function automatic logic is_cmp(input logic [7:0] a);
        return (a >= pin_ctrl_pkg::ADDR_CMP1) && (a <= pin_ctrl_pkg::ADDR_CMP5);
    endfunction

    function automatic logic [2:0] cmp_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - pin_ctrl_pkg::ADDR_CMP1;
        return d[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register writes; every enable bit clears on reset so pins stay general-purpose
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < pin_ctrl_pkg::NUM_CMP; i++) begin
                cmp_reg[i] <= pin_ctrl_pkg::RST_ZERO;
            end
        end else if (sfr_wr_i && is_cmp(sfr_addr_i)) begin
            cmp_reg[cmp_idx(sfr_addr_i)] <= sfr_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mser_reg <= pin_ctrl_pkg::RST_MSER;
        end else if (sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_MSER) begin
            // acknowledge-in bit is read only; it tracks the serial engine
            mser_reg <= sfr_wdata_i & ~pin_ctrl_pkg::MASK_MSRO;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ampc_reg <= pin_ctrl_pkg::RST_ZERO;
            ampk_reg <= pin_ctrl_pkg::RST_ZERO;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == pin_ctrl_pkg::ADDR_AMPC) begin
                ampc_reg <= sfr_wdata_i & pin_ctrl_pkg::MASK_AMPC;
            end else if (sfr_addr_i == pin_ctrl_pkg::ADDR_AMPK) begin
                ampk_reg <= sfr_wdata_i;
            end
        end
    end

    // status comes from another domain, so it is synchronised first
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= serial_ack_in_i;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data is registered; one cycle after the read strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= pin_ctrl_pkg::RST_ZERO;
            sfr_hit_o   <= 1'b0;
        end else if (sfr_rd_i) begin
            sfr_hit_o <= 1'b1;
            if (is_cmp(sfr_addr_i)) begin
                sfr_rdata_o <= (sfr_addr_i == pin_ctrl_pkg::ADDR_CMP1)
                             ? (cmp_reg[0] & pin_ctrl_pkg::MASK_CMP1)
                             : cmp_reg[cmp_idx(sfr_addr_i)];
            end else if (sfr_addr_i == pin_ctrl_pkg::ADDR_MSER) begin
                sfr_rdata_o <= mser_reg
                             | (ack_sync_reg ? pin_ctrl_pkg::MASK_MSRO : pin_ctrl_pkg::RST_ZERO);
            end else if (sfr_addr_i == pin_ctrl_pkg::ADDR_AMPC) begin
                sfr_rdata_o <= ampc_reg;
            end else if (sfr_addr_i == pin_ctrl_pkg::ADDR_AMPK) begin
                sfr_rdata_o <= ampk_reg;
            end else begin
                sfr_rdata_o <= pin_ctrl_pkg::RST_ZERO;
                sfr_hit_o   <= 1'b0;
            end
        end else begin
            sfr_hit_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparator enables and pin claims
    always_comb begin
        for (int i = 0; i < pin_ctrl_pkg::NUM_CMP; i++) begin
            comparator_enable_o[i]    = cmp_reg[i][pin_ctrl_pkg::EN_BIT];
            comparator_pin_claim_o[i] = cmp_reg[i][pin_ctrl_pkg::EN_BIT];
            comparator_setting_o[i]   = cmp_reg[i][pin_ctrl_pkg::SET_HI:0];
        end
    end
    // comparator one owns two pins; index 0 claim covers P1.3
    assign comparator_one_pin_p14_o = cmp_reg[0][pin_ctrl_pkg::EN_BIT];

    assign serial_master_enable_o = mser_reg[pin_ctrl_pkg::EN_BIT];
    assign serial_pins_claim_o    = mser_reg[pin_ctrl_pkg::EN_BIT];
    assign two_wire_master_ctrl_o = mser_reg[pin_ctrl_pkg::SET_HI:0];

    ////////////////////////////////////////////////////////////////////////////
    // amplifier network
    assign amp.enable   = ampc_reg[pin_ctrl_pkg::EN_BIT];
    assign amp.out_en   = ampc_reg[pin_ctrl_pkg::OE_BIT];
    assign amp.in_sel   = ampc_reg[pin_ctrl_pkg::SEL_HI:pin_ctrl_pkg::SEL_LO];
    assign amp.cal_mode = ampk_reg[pin_ctrl_pkg::MODE_BIT];
    assign amp.trim_bg  = ampk_reg[pin_ctrl_pkg::TRIM_BIT];

    amp_input_net u_net (
        .cfg (amp.net)
    );

    assign amplifier_power_o       = amp.enable;
    assign amplifier_pin_p10_o     = amp.pin_p10_amp;
    assign amplifier_pin_p11_o     = amp.pin_p11_amp;
    // P1.6 is also the fourth comparator input; this claim and the comparator four claim are driven independently
    assign amplifier_pin_p16_out_o = amp.pin_p16_out;
    assign amplifier_pos_src_o     = amp.pos_src;
    assign amplifier_neg_src_o     = amp.neg_src;
    assign amplifier_pos_res_o     = amp.pos_res;
    assign amplifier_inner_gain_o  = amp.inner_gain;
    assign amplifier_trim_bg_o     = amp.trim_sel;
    assign amplifier_trim_adj_o    = ampk_reg[pin_ctrl_pkg::ADJ_HI:0];
    assign amplifier_gain_o        = ampc_reg[pin_ctrl_pkg::GAIN_HI:0];
endmodule // analog_peripheral_pin_control
`default_nettype wire

/* File: include/amp_cfg_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface amp_cfg_if;
    logic       enable;
    logic       out_en;
    logic       cal_mode;
    logic [1:0] in_sel;
    logic       trim_bg;
    pin_ctrl_pkg::amp_src_t pos_src;
    pin_ctrl_pkg::amp_src_t neg_src;
    logic       pos_res;
    logic       inner_gain;
    logic       trim_sel;
    logic       pin_p10_amp;
    logic       pin_p11_amp;
    logic       pin_p16_out;
    modport ctrl (output enable, out_en, cal_mode, in_sel, trim_bg,
                  input pos_src, neg_src, pos_res, inner_gain, trim_sel,
                  pin_p10_amp, pin_p11_amp, pin_p16_out);
    modport net  (input enable, out_en, cal_mode, in_sel, trim_bg,
                  output pos_src, neg_src, pos_res, inner_gain, trim_sel,
                  pin_p10_amp, pin_p11_amp, pin_p16_out);
endinterface
`default_nettype wire

/* File: include/pin_ctrl_pkg.sv */
`default_nettype none
package pin_ctrl_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_CMP1 = 8'hC1;
    localparam logic [7:0] ADDR_CMP2 = 8'hC2;
    localparam logic [7:0] ADDR_CMP3 = 8'hC3;
    localparam logic [7:0] ADDR_CMP4 = 8'hC4;
    localparam logic [7:0] ADDR_CMP5 = 8'hC5;
    localparam logic [7:0] ADDR_MSER = 8'hE1;
    localparam logic [7:0] ADDR_AMPC = 8'hEE;
    localparam logic [7:0] ADDR_AMPK = 8'hEF;
    // field positions
    localparam int EN_BIT      = 7;
    localparam int OE_BIT      = 5;
    localparam int SEL_HI      = 4;
    localparam int SEL_LO      = 3;
    localparam int MODE_BIT    = 6;
    localparam int TRIM_BIT    = 5;
    localparam int STATUS_BIT  = 4;
    localparam int SET_HI      = 6;
    localparam int ADJ_HI      = 4;
    localparam int GAIN_HI     = 1;
    localparam int NUM_CMP     = 5;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_MSER = 8'h04;
    // register masks: reserved bits read as zero; MASK_MSRO marks the read-only status bit 4
    localparam logic [7:0] MASK_CMP1 = 8'hDF;
    localparam logic [7:0] MASK_AMPC = 8'hBF;
    localparam logic [7:0] MASK_ALL  = 8'hFF;
    localparam logic [7:0] MASK_MSRO = 8'h10;
    // input select codes
    localparam logic [1:0] SEL_POS_GAIN = 2'h0;
    localparam logic [1:0] SEL_NEG_GAIN = 2'h1;
    localparam logic [1:0] SEL_NEG_RES  = 2'h2;
    localparam logic [1:0] SEL_BOTH_EXT = 2'h3;
    // amplifier input network sources
    typedef enum logic [1:0] {SRC_GND, SRC_PIN, SRC_TRIM} amp_src_t;
endpackage
`default_nettype wire

/* File: sim/analog_peripheral_pin_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module analog_peripheral_pin_control_tb;
    typedef struct packed {logic m; logic [1:0] s, p, n; logic r, g;} row_t;
    logic core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, serial_ack_in_i, sfr_hit_o, hq;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, q;
    logic comparator_one_pin_p14_o, serial_master_enable_o, serial_pins_claim_o;
    logic [4:0] comparator_enable_o, comparator_pin_claim_o, amplifier_trim_adj_o;
    logic [6:0] two_wire_master_ctrl_o;
    logic amplifier_power_o, amplifier_pin_p10_o, amplifier_pin_p11_o, amplifier_pin_p16_out_o;
    logic [1:0] amplifier_pos_src_o, amplifier_neg_src_o, amplifier_gain_o;
    logic amplifier_pos_res_o, amplifier_inner_gain_o, amplifier_trim_bg_o;
    logic [6:0] comparator_setting_o [5];
    int n_errors = 0;
    int n_checks = 0;
    // mode, select, positive and negative source, resistor, inner gain
    row_t rows [8] = '{'{0,0,1,0,0,1}, '{0,1,0,1,0,1}, '{0,2,0,1,1,1}, '{0,3,1,1,0,0},
                      '{1,0,2,2,0,0}, '{1,1,0,0,0,1}, '{1,2,0,0,1,1}, '{1,3,1,1,0,0}};
    logic [7:0] ra [8] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hE1, 8'hEE, 8'hEF};
    logic [7:0] ov [3] = '{8'h20, 8'hA0, 8'h80};
    analog_peripheral_pin_control u_dut (.core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .serial_ack_in_i,
        .comparator_enable_o, .comparator_pin_claim_o, .comparator_one_pin_p14_o,
        .serial_master_enable_o, .serial_pins_claim_o, .two_wire_master_ctrl_o,
        .amplifier_power_o, .amplifier_pin_p10_o, .amplifier_pin_p11_o, .amplifier_pin_p16_out_o,
        .amplifier_pos_src_o, .amplifier_neg_src_o, .amplifier_pos_res_o, .amplifier_inner_gain_o,
        .amplifier_trim_bg_o, .amplifier_trim_adj_o, .amplifier_gain_o, .comparator_setting_o);
    ////////////////////////////////////////////////////////////////////////////////
    // an idle edge before each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1 {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'h1};
        @(posedge core_clk_i);
        #1 sfr_wr_i = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        #1 {sfr_addr_i, sfr_rd_i} = {a, 1'h1};
        @(posedge core_clk_i);
        #1 sfr_rd_i = 1'h0;
        {q, hq} = {sfr_rdata_o, sfr_hit_o};
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        core_clk_i = 1'h0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    initial begin
        #(40 * 3000);
        n_errors++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, sfr_wr_i, sfr_rd_i, serial_ack_in_i, sfr_addr_i, sfr_wdata_i} = {4'h8, 16'h0000};
        repeat (6) @(posedge core_clk_i);
        #1 rst_i = 1'h0;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            `CHK("reset value", (i == 5) ? 8'h04 : 8'h00, q)
        end
        `CHK("enables after reset", 8'h00, {comparator_enable_o, serial_master_enable_o,
            amplifier_power_o, amplifier_pin_p16_out_o})
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], 8'h80);
            `CHK("cmp enable", 5'h01 << i, comparator_enable_o)
            `CHK("cmp claim", 5'h01 << i, comparator_pin_claim_o)
            `CHK("cmp one second pin", i == 0, comparator_one_pin_p14_o)
            wr(ra[i], 8'h7F);
            `CHK("cmp off", 5'h00, comparator_enable_o)
            `CHK("cmp setting", 7'h7F, comparator_setting_o[i])
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'hEF, {1'h0, rows[i].m, 6'h00});
            wr(8'hEE, {3'h4, rows[i].s, 3'h0});
            `CHK("amp sources", {rows[i].p, rows[i].n}, {amplifier_pos_src_o, amplifier_neg_src_o})
            `CHK("amp res gain", {rows[i].r, rows[i].g}, {amplifier_pos_res_o, amplifier_inner_gain_o})
            `CHK("amp pins", {rows[i].p == 2'h1, rows[i].n == 2'h1},
                {amplifier_pin_p10_o, amplifier_pin_p11_o})
        end
        wr(8'hEF, 8'h75);
        `CHK("trim ground or bandgap", 1'h1, amplifier_trim_bg_o)
        `CHK("trim adjust", 5'h15, amplifier_trim_adj_o)
        wr(8'hEF, 8'h00);
        `CHK("trim cleared", 6'h00, {amplifier_trim_bg_o, amplifier_trim_adj_o})
        for (int i = 0; i < 3; i++) begin
            wr(8'hEE, ov[i]);
            `CHK("amp out pin", ov[i][7] & ov[i][5], amplifier_pin_p16_out_o)
            `CHK("amp power", ov[i][7], amplifier_power_o)
        end
        wr(8'hEE, 8'h20);
        `CHK("pin claim when off", 2'h0, {amplifier_pin_p10_o, amplifier_pin_p11_o})
        // status bit 4 is read only, so the write of B7 keeps A7
        wr(8'hE1, 8'hB7);
        `CHK("serial claim", 9'h1A7, {serial_master_enable_o, serial_pins_claim_o, two_wire_master_ctrl_o})
        rd(8'hE1);
        `CHK("serial status fixed", 8'hA7, q)
        @(posedge core_clk_i);
        #1 serial_ack_in_i = 1'h1;
        rd(8'hE1);
        rd(8'hE1);
        `CHK("serial status bit", 8'hB7, q)
        wr(8'hE1, 8'h00);
        `CHK("serial off", 9'h000, {serial_master_enable_o, serial_pins_claim_o, two_wire_master_ctrl_o})
        wr(8'hC1, 8'hFF);
        rd(8'hC1);
        `CHK("reserved bit", 9'h1BF, {q, hq})
        wr(8'hEE, 8'hFF);
        `CHK("amp gain", 2'h3, amplifier_gain_o)
        rd(8'hEE);
        `CHK("reserved bit", 9'h17F, {q, hq})
        rd(8'h55);
        `CHK("unmapped read", 9'h000, {q, hq})
        @(posedge core_clk_i);
        #1 rst_i = 1'h1;
        @(posedge core_clk_i);
        #1 rst_i = 1'h0;
        `CHK("enables after reset", 8'h00, {comparator_enable_o, serial_master_enable_o,
            amplifier_power_o, amplifier_pin_p16_out_o})
        tally_and_finish();
    end
endmodule // analog_peripheral_pin_control_tb
`undef CHK
`default_nettype wire

/* File: sim/pin_ctrl_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_ctrl_checker (
    // clock, reset and register port
    input wire logic       core_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    // pin control
    input wire logic [4:0] comparator_enable_o,
    input wire logic       serial_master_enable_o,
    input wire logic       amplifier_power_o,
    input wire logic       amplifier_pin_p16_out_o,
    input wire logic [1:0] amplifier_pos_src_o,
    input wire logic [1:0] amplifier_neg_src_o,
    input wire logic       amplifier_pos_res_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_cmp1;
        sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_CMP1
        |=> comparator_enable_o[0] == $past(sfr_wdata_i[7]);
    endproperty
    a_cmp1: assert property (p_cmp1) else $error("comparator one enable wrong");
    property p_cmp4;
        sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_CMP4
        |=> comparator_enable_o[3] == $past(sfr_wdata_i[7]);
    endproperty
    a_cmp4: assert property (p_cmp4) else $error("comparator four enable wrong");
    property p_ser;
        sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_MSER
        |=> serial_master_enable_o == $past(sfr_wdata_i[7]);
    endproperty
    a_ser: assert property (p_ser) else $error("serial master enable wrong");
    property p_amp;
        sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_AMPC
        |=> amplifier_power_o == $past(sfr_wdata_i[7]);
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier power wrong");
    property p_p16;
        sfr_wr_i && sfr_addr_i == pin_ctrl_pkg::ADDR_AMPC
        |=> amplifier_pin_p16_out_o == ($past(sfr_wdata_i[7]) && $past(sfr_wdata_i[5]));
    endproperty
    a_p16: assert property (p_p16) else $error("amplifier output pin wrong");
    property p_trim;
        amplifier_pos_src_o == pin_ctrl_pkg::SRC_TRIM |-> amplifier_neg_src_o == amplifier_pos_src_o;
    endproperty
    a_trim: assert property (p_trim) else $error("trim inputs not paired");
    property p_res;
        amplifier_pos_res_o |-> amplifier_pos_src_o == pin_ctrl_pkg::SRC_GND;
    endproperty
    a_res: assert property (p_res) else $error("resistor path without ground");
    property p_rst;
        $fell(rst_i) |-> comparator_enable_o == 5'h00 && !serial_master_enable_o
            && !amplifier_power_o && !amplifier_pin_p16_out_o;
    endproperty
    a_rst: assert property (p_rst) else $error("enable left on after reset");
    c_p16: cover property (amplifier_pin_p16_out_o);
    c_trim: cover property (amplifier_pos_src_o == pin_ctrl_pkg::SRC_TRIM);
    c_ser: cover property (serial_master_enable_o);
endmodule // pin_ctrl_checker
bind analog_peripheral_pin_control pin_ctrl_checker u_chk (.core_clk_i, .rst_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .comparator_enable_o, .serial_master_enable_o, .amplifier_power_o,
    .amplifier_pin_p16_out_o, .amplifier_pos_src_o, .amplifier_neg_src_o, .amplifier_pos_res_o);
`default_nettype wire
